// ### logic/itmp_pkg.sv
`default_nettype none
package itmp_pkg;
   // 7-bit target address lives in bits 7:1
   localparam logic [7:0] ADDR_RST = 8'h86;
   localparam logic [7:0] PTR_RST = 8'hff;
   localparam logic [7:0] IDX_RSVD_LAST = 8'hfc;
   localparam logic [7:0] IDX_PEND_HI = 8'hfd;
   localparam logic [7:0] IDX_PEND_LO = 8'hfe;
   localparam logic [7:0] IDX_STREAM = 8'hff;
   localparam logic [7:0] EMPTY_FILL = 8'hff;
   localparam logic [7:0] RSVD_VALUE = 8'h00;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int OBUF_AW = 8;
   localparam int RXF_WIDTH = 8;
   localparam int RXF_DEPTH = 16;
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_ADDR = 8'h02,
      ST_AACK = 8'h04,
      ST_WRX = 8'h08,
      ST_WACK = 8'h10,
      ST_RFETCH = 8'h20,
      ST_RTX = 8'h40,
      ST_RACK = 8'h80
   } itmp_state_e;
endpackage : itmp_pkg
`default_nettype wire

// ### logic/itmp_top.sv
// Summary of operation
// (RULE1) The port is a bus target only, for serial clocks up to 400 kHz.
// (RULE2) The target address is an 8-bit setting, 0x86 by default (0x43).
// (RULE3) An 8-bit index spans 256 bytes; 0x00 to 0xFC are reserved.
// (RULE4) Indices 0xFD and 0xFE return the count of bytes waiting.
// (RULE5) Index 0xFF pops the next stream byte, or 0xFF when empty.
// (RULE6) A random read is start, address+write, index, restart, reads.
// (RULE7) The pointer steps after each byte read unless it equals 0xFF.
// (RULE8) The pointer equals 0xFF after reset.
// (RULE9) A matching address is acknowledged by pulling data low.
// (RULE10) Written bytes only become incoming message content.
// (RULE11) A message write holds at least two data bytes.
// (RULE12) A new message that does not fit is dropped whole.
// (RULE13) The port works only while the interface select pin is high.
// (RULE14) A write of exactly one byte loads the pointer instead.
// (RULE15) The count pair is high byte first, sampled once per pair.
`timescale 1ns/1ps
`default_nettype none
// depth must be a power of two
module itmp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
   logic [AW:0] fill, next_fill;
   logic push, pop;
   assign inReady = (fill != (AW+1)'(DEPTH));
   assign outValid = (fill != '0);
   assign outData = mem[rdPtr];
   always_comb begin
      push = inValid && inReady;
      pop = outValid && outReady;
      next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
      next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
      next_fill = fill + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         fill <= '0;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         fill <= next_fill;
      end
   end
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end
endmodule : itmp_fifo

module itmp_top #(
   parameter logic [7:0] TARGET_ADDR = itmp_pkg::ADDR_RST // RULE2
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic linkClk,
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOe,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic selI2c,
   input wire logic [7:0] txData,
   input wire logic txValid,
   input wire logic txLast,
   output logic [7:0] rxData,
   output logic rxValid,
   input wire logic rxReady
);
   import itmp_pkg::*;
   // link domain: oversamples the pins; never drives a clock of its own
   logic rstS1, linkRst, sclS1, sclS2, sclQ, sdaS1, sdaS2, sdaQ;
   logic selS1, selS2, rdAckS1, rdAckS2, rdAckSeen, rxAckS1, rxAckS2;
   logic sclRise, sclFall, startC, stopC, rdDone, rxBusy, fetch;
   itmp_state_e state, next_state;
   logic [3:0] bitCnt, next_bitCnt;
   logic [7:0] shReg, next_shReg, txSh, next_txSh, ptr, next_ptr;
   logic [7:0] holdByte, next_hold, rdIdx, next_rdIdx;
   logic [1:0] wrCnt, next_wrCnt;
   logic rwBit, next_rwBit, ackBit, next_ackBit, next_sdaOe, next_sclOe;
   logic rdReq, next_rdReq, rxReq, next_rxReq;
   logic [16:0] rxPay, next_rxPay;
   // system domain
   logic [7:0] obuf [2**OBUF_AW];
   logic [8:0] wrTent, next_wrTent, wrCommit, next_wrCommit;
   logic [8:0] rdPtr, next_rdPtr, pend;
   logic [15:0] pendCount;
   logic [7:0] rdData, next_rdData, snapLo, next_snapLo, fifoIn;
   logic dropping, next_drop, full, wrEn, fits, srvGo;
   logic rdReqS1, rdReqS2, rdAck, next_rdAck;
   logic rxReqS1, rxReqS2, rxAck, next_rxAck, sentFirst, next_sentFirst;
   logic rxNew, fifoReady;

   always_ff @(posedge linkClk) begin
      rstS1 <= sys_rst;
      linkRst <= rstS1;
      sclS1 <= sclIn;
      sclS2 <= sclS1;
      sclQ <= sclS2;
      sdaS1 <= sdaIn;
      sdaS2 <= sdaS1;
      sdaQ <= sdaS2;
      selS1 <= selI2c;
      selS2 <= selS1;
      rdAckS1 <= rdAck;
      rdAckS2 <= rdAckS1;
      rdAckSeen <= rdAckS2;
      rxAckS1 <= rxAck;
      rxAckS2 <= rxAckS1;
   end

   assign sclRise = sclS2 && !sclQ;
   assign sclFall = !sclS2 && sclQ;
   assign startC = sclS2 && sclQ && sdaQ && !sdaS2;
   assign stopC = sclS2 && sclQ && !sdaQ && sdaS2;
   assign rdDone = (rdAckS2 != rdAckSeen);
   assign rxBusy = (rxReq != rxAckS2);

   // target only: no arbitration, clock is driven low only to stretch
   always_comb begin // RULE1
      next_state = state;
      next_bitCnt = bitCnt;
      next_shReg = shReg;
      next_txSh = txSh;
      next_rwBit = rwBit;
      next_ackBit = ackBit;
      next_ptr = ptr;
      next_hold = holdByte;
      next_wrCnt = wrCnt;
      next_sdaOe = sdaOe;
      next_sclOe = sclOe;
      next_rdReq = rdReq;
      next_rdIdx = rdIdx;
      next_rxReq = rxReq;
      next_rxPay = rxPay;
      fetch = 1'b0;
      if (!selS2) begin // RULE13
         next_state = ST_IDLE;
         next_sdaOe = 1'b0;
         next_sclOe = 1'b0;
         next_wrCnt = 2'h0;
      end else if (startC || stopC) begin
         if (wrCnt == 2'h1) begin
            next_ptr = holdByte; // RULE14
         end
         next_wrCnt = 2'h0;
         next_sdaOe = 1'b0;
         next_sclOe = 1'b0;
         next_bitCnt = 4'h0;
         next_state = startC ? ST_ADDR : ST_IDLE;
      end else begin
         if (sclRise) begin
            next_shReg = {shReg[6:0], sdaS2};
            next_bitCnt = bitCnt + 4'h1;
            if (state == ST_RACK) begin
               next_ackBit = sdaS2;
            end
         end
         case (state)
            ST_IDLE: begin
            end
            ST_ADDR: begin
               if (sclFall && bitCnt == BYTE_BITS) begin
                  if (shReg[7:1] == TARGET_ADDR[7:1]) begin
                     next_state = ST_AACK;
                     next_sdaOe = 1'b1; // RULE9
                     next_rwBit = shReg[0];
                  end else begin
                     next_state = ST_IDLE;
                  end
               end
            end
            ST_AACK: begin
               if (sclFall) begin
                  next_sdaOe = 1'b0;
                  next_bitCnt = 4'h0;
                  next_state = rwBit ? ST_RFETCH : ST_WRX;
                  fetch = rwBit;
               end
            end
            ST_WRX: begin
               if (sclFall && bitCnt == BYTE_BITS) begin
                  if (wrCnt == 2'h0) begin
                     // first byte is held: a pointer load if alone, message content if more follow
                     next_hold = shReg; // RULE11
                     next_wrCnt = 2'h1;
                     next_state = ST_WACK;
                     next_sdaOe = 1'b1;
                  end else if (rxBusy) begin
                     // no room: leave the acknowledge slot undriven
                     next_state = ST_IDLE;
                  end else begin
                     next_rxPay = {wrCnt == 2'h1, holdByte, shReg}; // RULE10
                     next_rxReq = !rxReq;
                     next_wrCnt = 2'h2;
                     next_state = ST_WACK;
                     next_sdaOe = 1'b1;
                  end
               end
            end
            ST_WACK: begin
               if (sclFall) begin
                  next_sdaOe = 1'b0;
                  next_bitCnt = 4'h0;
                  next_state = ST_WRX;
               end
            end
            ST_RFETCH: begin
               next_sclOe = 1'b1;
               if (rdDone) begin
                  next_txSh = rdData;
                  next_sdaOe = !rdData[7];
                  next_bitCnt = 4'h0;
                  next_state = ST_RTX;
               end
            end
            ST_RTX: begin
               // clock released a cycle after data, for setup time
               next_sclOe = 1'b0;
               if (sclFall) begin
                  if (bitCnt == BYTE_BITS) begin
                     next_sdaOe = 1'b0;
                     next_state = ST_RACK;
                  end else begin
                     next_txSh = {txSh[6:0], 1'b0};
                     next_sdaOe = !txSh[6];
                  end
               end
            end
            ST_RACK: begin
               if (sclFall) begin
                  fetch = !ackBit;
                  next_state = ackBit ? ST_IDLE : ST_RFETCH;
               end
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
         if (fetch) begin
            next_rdIdx = ptr;
            next_rdReq = !rdReq;
            if (ptr != IDX_STREAM) begin
               next_ptr = ptr + 8'h01; // RULE7
            end
         end
      end
   end

   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         state <= ST_IDLE;
         bitCnt <= 4'h0;
         shReg <= 8'h00;
         txSh <= 8'h00;
         rwBit <= 1'b0;
         ackBit <= 1'b1;
         ptr <= PTR_RST; // RULE8
         holdByte <= 8'h00;
         wrCnt <= 2'h0;
         sdaOe <= 1'b0;
         sclOe <= 1'b0;
         sdaOut <= 1'b0;
         sclOut <= 1'b0;
         rdReq <= 1'b0;
         rdIdx <= PTR_RST;
         rxReq <= 1'b0;
         rxPay <= 17'h00000;
      end else begin
         state <= next_state;
         bitCnt <= next_bitCnt;
         shReg <= next_shReg;
         txSh <= next_txSh;
         rwBit <= next_rwBit;
         ackBit <= next_ackBit;
         ptr <= next_ptr;
         holdByte <= next_hold;
         wrCnt <= next_wrCnt;
         sdaOe <= next_sdaOe;
         sclOe <= next_sclOe;
         sdaOut <= 1'b0;
         sclOut <= 1'b0;
         rdReq <= next_rdReq;
         rdIdx <= next_rdIdx;
         rxReq <= next_rxReq;
         rxPay <= next_rxPay;
      end
   end

   // system side: outgoing buffer, register server, incoming unpacker
   assign pend = wrCommit - rdPtr;
   assign pendCount = {7'h00, pend};
   assign full = ((wrTent - rdPtr) == 9'h100);
   assign wrEn = txValid && !dropping && !full;
   assign fits = !dropping && !full;
   assign srvGo = (rdReqS2 != rdAck);
   assign rxNew = (rxReqS2 != rxAck);
   assign fifoIn = (rxPay[16] && !sentFirst) ? rxPay[15:8] : rxPay[7:0];

   always_comb begin
      next_wrTent = wrEn ? wrTent + 9'h001 : wrTent;
      next_wrCommit = wrCommit;
      next_drop = dropping;
      next_rdPtr = rdPtr;
      next_rdData = rdData;
      next_snapLo = snapLo;
      next_rdAck = rdAck;
      next_rxAck = rxAck;
      next_sentFirst = sentFirst;
      if (txValid && txLast) begin
         next_drop = 1'b0;
         if (fits) begin
            next_wrCommit = wrTent + 9'h001;
         end else begin
            next_wrTent = wrCommit; // RULE12
         end
      end else if (txValid && full) begin
         next_drop = 1'b1;
      end
      if (srvGo) begin
         next_rdAck = rdReqS2;
         case (rdIdx) // RULE3
            IDX_PEND_HI: begin
               next_rdData = pendCount[15:8]; // RULE4
               next_snapLo = pendCount[7:0]; // RULE15
            end
            IDX_PEND_LO: begin
               next_rdData = snapLo; // RULE15
            end
            IDX_STREAM: begin
               if (pend != 9'h000) begin
                  next_rdData = obuf[rdPtr[7:0]]; // RULE5
                  next_rdPtr = rdPtr + 9'h001;
               end else begin
                  next_rdData = EMPTY_FILL; // RULE5
               end
            end
            default: begin
               next_rdData = RSVD_VALUE;
            end
         endcase
      end
      if (rxNew && fifoReady) begin
         if (rxPay[16] && !sentFirst) begin
            next_sentFirst = 1'b1;
         end else begin
            next_sentFirst = 1'b0;
            next_rxAck = rxReqS2;
         end
      end
   end

   always_ff @(posedge clk) begin
      rdReqS1 <= rdReq;
      rdReqS2 <= rdReqS1;
      rxReqS1 <= rxReq;
      rxReqS2 <= rxReqS1;
      if (sys_rst) begin
         wrTent <= 9'h000;
         wrCommit <= 9'h000;
         dropping <= 1'b0;
         rdPtr <= 9'h000;
         rdData <= EMPTY_FILL;
         snapLo <= 8'h00;
         rdAck <= 1'b0;
         rxAck <= 1'b0;
         sentFirst <= 1'b0;
      end else begin
         wrTent <= next_wrTent;
         wrCommit <= next_wrCommit;
         dropping <= next_drop;
         rdPtr <= next_rdPtr;
         rdData <= next_rdData;
         snapLo <= next_snapLo;
         rdAck <= next_rdAck;
         rxAck <= next_rxAck;
         sentFirst <= next_sentFirst;
      end
   end

   always_ff @(posedge clk) begin
      if (wrEn) begin
         obuf[wrTent[7:0]] <= txData;
      end
   end

   itmp_fifo #(.WIDTH(RXF_WIDTH), .DEPTH(RXF_DEPTH)) rxFifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .inData(fifoIn),
      .inValid(rxNew),
      .inReady(fifoReady),
      .outData(rxData),
      .outValid(rxValid),
      .outReady(rxReady)
   );

   sequence s_srv(logic [7:0] idx);
      srvGo && rdIdx == idx;
   endsequence
   sequence s_fetchTop;
      fetch && ptr == IDX_STREAM;
   endsequence
   sequence s_addrHit;
      state == ST_ADDR && selS2 && !startC && !stopC && sclFall &&
         bitCnt == BYTE_BITS && shReg[7:1] == TARGET_ADDR[7:1];
   endsequence

   a_fill_empty: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
      s_srv(IDX_STREAM) ##0 (pend == 9'h000) |=> rdData == EMPTY_FILL)
      else $error("empty stream read did not return filler");
   a_stream_pop: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
      s_srv(IDX_STREAM) ##0 (pend != 9'h000)
      |=> rdPtr == $past(rdPtr) + 9'h001)
      else $error("stream read did not pop one byte");
   a_pend_high: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
      s_srv(IDX_PEND_HI) |=> rdData == $past(pendCount[15:8]))
      else $error("count high byte wrong");
   // reads of a pair lie thousands of cycles apart, so check each step
   a_pend_snap: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
      s_srv(IDX_PEND_HI) |=> snapLo == $past(pendCount[7:0]))
      else $error("count low byte not sampled with high byte");
   a_pend_low: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
      s_srv(IDX_PEND_LO) |=> rdData == $past(snapLo) && $stable(snapLo))
      else $error("count low byte not from same sample");
   a_rsvd_zero: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
      srvGo && rdIdx <= IDX_RSVD_LAST |=> rdData == RSVD_VALUE)
      else $error("reserved index returned data");
   a_drop_whole: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
      txValid && txLast && !fits
      |=> wrCommit == $past(wrCommit) && wrTent == wrCommit)
      else $error("oversized message not dropped");
   a_ptr_stay: assert property (@(posedge linkClk) disable iff (linkRst) // RULE7
      s_fetchTop |=> ptr == IDX_STREAM)
      else $error("pointer moved past top index");
   a_ptr_step: assert property (@(posedge linkClk) disable iff (linkRst) // RULE7
      fetch && ptr != IDX_STREAM |=> ptr == $past(ptr) + 8'h01)
      else $error("pointer did not step after read");
   a_ptr_init: assert property (@(posedge linkClk) disable iff (linkRst) // RULE8
      $fell(linkRst) |-> ptr == PTR_RST)
      else $error("pointer not at top index after reset");
   a_addr_ack: assert property (@(posedge linkClk) disable iff (linkRst) // RULE9
      s_addrHit |=> sdaOe && state == ST_AACK ##1 sdaOe)
      else $error("own address not acknowledged");
   a_single_ptr: assert property (@(posedge linkClk) disable iff (linkRst) // RULE14
      selS2 && (stopC || startC) && wrCnt == 2'h1
      |=> ptr == $past(holdByte) && rxReq == $past(rxReq))
      else $error("single byte write did not load pointer");
endmodule : itmp_top
`default_nettype wire

// ### dv/itmp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// fast-mode bus controller, open drain on both lines
module itmp_host_model (
   input wire logic scl,
   input wire logic sda,
   output logic mSclOe,
   output logic mSdaOe
);
   // 1300 ns low plus 1200 ns high keeps scl at 400 kHz
   localparam int TQ = 650;
   initial begin
      mSclOe = 1'b0;
      mSdaOe = 1'b0;
   end
   // bounded wait, the target may stretch scl low for read data
   task automatic relScl();
      int n;
      n = 0;
      mSclOe = 1'b0;
      while (scl !== 1'b1 && n < 500) begin
         #20;
         n++;
      end
   endtask : relScl
   task automatic bitIo(input logic b, output logic r);
      #TQ mSdaOe = !b;
      #TQ relScl();
      #600 r = sda;
      #600 mSclOe = 1'b1;
   endtask : bitIo
   // also serves as repeated start when scl is low
   task automatic start();
      #TQ mSdaOe = 1'b0;
      #TQ relScl();
      #600 mSdaOe = 1'b1;
      #600 mSclOe = 1'b1;
   endtask : start
   task automatic stop();
      #TQ mSdaOe = 1'b1;
      #TQ relScl();
      #600 mSdaOe = 1'b0;
      #1300;
   endtask : stop
   // send d (0xff to read), then put a in the ack slot; ok = slot low
   task automatic xfer(input logic [7:0] d, input logic a,
                       output logic [7:0] q, output logic ok);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitIo(d[i], q[i]);
      end
      bitIo(a, r);
      ok = !r;
   endtask : xfer
endmodule : itmp_host_model
`default_nettype wire

// ### dv/itmp_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module itmp_top_tb;
   localparam logic [7:0] AW = itmp_pkg::ADDR_RST & 8'hfe;
   localparam logic [7:0] AR = itmp_pkg::ADDR_RST | 8'h01;
   logic clk = 1'b0;
   logic linkClk = 1'b0;
   logic sysRst = 1'b1;
   logic selI2c = 1'b1;
   logic [7:0] txData = 8'h00;
   logic txValid = 1'b0;
   logic txLast = 1'b0;
   logic rxReady = 1'b1;
   wire logic scl, sda, sclOe, sdaOe, mSclOe, mSdaOe, rxValid;
   wire logic [7:0] rxData;
   wire logic sclOutPin, sdaOutPin;
   logic [7:0] rd [8];
   logic [7:0] wr [20];
   logic [7:0] rxQ [$];
   int badCount = 0;
   int nTests = 0;
   int acked;
   always #4 clk = !clk;
   initial #13 forever #80 linkClk = !linkClk;
   // both lines pulled up, low while anyone drives
   assign scl = !(sclOe | mSclOe);
   assign sda = !(sdaOe | mSdaOe);
   itmp_top dut_u (.clk(clk), .sys_rst(sysRst), .linkClk(linkClk),
      .sclIn(scl), .sclOut(sclOutPin), .sclOe(sclOe), .sdaIn(sda),
      .sdaOut(sdaOutPin), .sdaOe(sdaOe), .selI2c(selI2c), .txData(txData),
      .txValid(txValid), .txLast(txLast), .rxData(rxData),
      .rxValid(rxValid), .rxReady(rxReady));
   itmp_host_model host_u (.scl(scl), .sda(sda), .mSclOe(mSclOe),
      .mSdaOe(mSdaOe));
   always @(posedge clk) begin
      if (rxValid === 1'b1 && rxReady === 1'b1) begin
         rxQ.push_back(rxData);
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      nTests++;
      if (got !== exp) begin
         badCount++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic results();
      $display("mismatches %0d, checks %0d", badCount, nTests);
      if (badCount == 0 && nTests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   task automatic pushMsg(input int n, input logic [7:0] base);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         #1;
         txData = base + 8'(i);
         txValid = 1'b1;
         txLast = (i == n - 1);
      end
      @(posedge clk);
      #1;
      txValid = 1'b0;
      txLast = 1'b0;
   endtask : pushMsg
   task automatic rdBytes(input logic useIdx, input logic [7:0] idx,
                          input int n);
      logic ok;
      logic [7:0] q;
      host_u.start();
      if (useIdx) begin
         host_u.xfer(AW, 1'b1, q, ok);
         check(16'(ok), 16'h0001);
         host_u.xfer(idx, 1'b1, q, ok);
         host_u.start();
      end
      host_u.xfer(AR, 1'b1, q, ok);
      check(16'(ok), 16'h0001);
      for (int i = 0; i < n; i++) begin
         host_u.xfer(8'hff, i == n - 1, rd[i], ok);
      end
      host_u.stop();
   endtask : rdBytes
   // stops at the first refused byte
   task automatic wrBytes(input int n);
      logic ok;
      logic [7:0] q;
      acked = 0;
      host_u.start();
      host_u.xfer(AW, 1'b1, q, ok);
      check(16'(ok), 16'h0001);
      for (int i = 0; i < n && ok === 1'b1; i++) begin
         host_u.xfer(wr[i], 1'b1, q, ok);
         if (ok === 1'b1) acked++;
      end
      host_u.stop();
   endtask : wrBytes
   task automatic waitRx(input int n);
      for (int i = 0; i < 4000 && rxQ.size() < n; i++) @(posedge clk);
   endtask : waitRx
   task automatic tEmpty();
      rdBytes(1'b0, 8'h00, 2);
      check(rd[0], itmp_pkg::EMPTY_FILL);
      check(rd[1], itmp_pkg::EMPTY_FILL);
   endtask : tEmpty
   task automatic tStream();
      pushMsg(3, 8'h10);
      pushMsg(2, 8'h20);
      rdBytes(1'b1, 8'hfc, 6);
      check(rd[0], itmp_pkg::RSVD_VALUE);
      check({rd[1], rd[2]}, 16'h0005);
      check({rd[3], rd[4]}, 16'h1011);
      check(rd[5], 8'h12);
      rdBytes(1'b0, 8'h00, 3);
      check({rd[0], rd[1]}, 16'h2021);
      check(rd[2], itmp_pkg::EMPTY_FILL);
   endtask : tStream
   task automatic tNoAck();
      logic ok;
      logic [7:0] q;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         #1;
         selI2c = (k == 0);
         repeat (8) @(posedge linkClk);
         host_u.start();
         host_u.xfer(k == 0 ? 8'h88 : AW, 1'b1, q, ok);
         host_u.stop();
         check(16'(ok), 16'h0000);
      end
      check({14'h0000, sclOutPin, sdaOutPin}, 16'h0000);
      @(posedge clk);
      #1;
      selI2c = 1'b1;
      repeat (8) @(posedge linkClk);
   endtask : tNoAck
   task automatic tWrite();
      rxQ.delete();
      for (int i = 0; i < 3; i++) wr[i] = 8'ha1 + 8'(i);
      wrBytes(3);
      waitRx(3);
      check(16'(rxQ.size()), 16'h0003);
      for (int i = 0; i < 3; i++) check(rxQ[i], 8'ha1 + 8'(i));
      wr[0] = 8'hfc;
      wrBytes(1);
      rdBytes(1'b0, 8'h00, 2);
      check({rd[0], rd[1]}, 16'h0000);
      check(16'(rxQ.size()), 16'h0003);
   endtask : tWrite
   // consumer stalls, so the fifo fills until a byte is refused
   task automatic tFifo();
      rxQ.delete();
      @(posedge clk);
      #1;
      rxReady = 1'b0;
      for (int i = 0; i < 20; i++) wr[i] = 8'h40 + 8'(i);
      wrBytes(20);
      check(16'(acked >= 16 && acked < 20), 16'h0001);
      @(posedge clk);
      #1;
      rxReady = 1'b1;
      waitRx(acked);
      check(16'(rxQ.size()), 16'(acked));
      for (int i = 0; i < acked; i++) check(rxQ[i], 8'h40 + 8'(i));
   endtask : tFifo
   task automatic tOverflow();
      pushMsg(256, 8'h00);
      pushMsg(1, 8'h55);
      rdBytes(1'b1, itmp_pkg::IDX_PEND_HI, 2);
      check({rd[0], rd[1]}, 16'h0100);
   endtask : tOverflow
   initial begin
      // reset spans link edges too, it is resynced there
      repeat (4) @(posedge linkClk);
      repeat (3) @(posedge clk);
      #1;
      sysRst = 1'b0;
      repeat (6) @(posedge linkClk);
      tEmpty();
      tStream();
      tNoAck();
      tWrite();
      tFifo();
      tOverflow();
      results();
   end
   initial begin
      #3000000;
      badCount++;
      $display("watchdog expired at %0t", $time);
      results();
   end
endmodule : itmp_top_tb
`default_nettype wire
